// ==== hdl/fstc_pkg.sv ====
// constants, carriers and helpers for the fft sample transfer control block
// assumes one system clock; strobes arrive as ordinary synchronous inputs
package fstc_pkg;

    // widths and depths
    localparam int DATA_W     = 32;
    localparam int ADDR_W     = 10;
    localparam int CNT_W      = 11;
    localparam int CFG_W      = 16;
    localparam int FIFO_DEPTH = 8;

    // block lengths and new-sample counts
    localparam logic [10:0] PTS_BIG     = 11'h400;
    localparam logic [10:0] PTS_SMALL   = 11'h100;
    localparam logic [10:0] PTS_HALF    = 11'h080;
    localparam logic [10:0] PTS_QUARTER = 11'h040;

    // circular window for the double-buffered small workspace
    localparam logic [9:0] CIRC_MASK  = 10'h1FF;
    localparam logic [9:0] SMALL_SPAN = 10'h100;

    // output strobe count that shows the first result; the three before it only prime
    localparam logic [2:0] PRIME_STROBES = 3'h4;

    // control word field positions
    localparam int CFG_SIZE_BIT = 0;
    localparam int CFG_OVL_LO   = 1;
    localparam int CFG_DIV_LO   = 3;
    localparam int CFG_WIN_LO   = 5;
    localparam int CFG_MODE_LO  = 9;
    localparam logic [15:0] CFG_RESET = 16'h0000;

    // field encodings
    localparam logic [1:0] MODE_SINGLE  = 2'h0;
    localparam logic [1:0] MODE_PSEUDO2 = 2'h2;
    localparam logic [1:0] OVL_HALF     = 2'h1;
    localparam logic [1:0] OVL_QUARTER  = 2'h2;
    localparam logic [1:0] DIV_BY2      = 2'h1;
    localparam logic [1:0] DIV_BY4      = 2'h2;

    // transform engine and dump sequencer states
    typedef enum logic [0:0] {
        XF_IDLE = 1'b0,
        XF_RUN  = 1'b1
    } fstc_xf_t;

    typedef enum logic [1:0] {
        DM_IDLE  = 2'b00,
        DM_PRIME = 2'b01,
        DM_AVAIL = 2'b10,
        DM_HOLD  = 2'b11
    } fstc_dm_t;

    // workspace write carrier
    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fstc_ws_wr_t;

    // samples making up a whole block
    function automatic logic [10:0] fstc_block_len(input logic [15:0] cfg);
        fstc_block_len = cfg[CFG_SIZE_BIT] ? PTS_BIG : PTS_SMALL;
    endfunction : fstc_block_len

    // new samples per transform once the workspace holds a block
    function automatic logic [10:0] fstc_new_len(input logic [15:0] cfg);
        logic [1:0] ovl;
        ovl = cfg[CFG_OVL_LO +: 2];
        if (cfg[CFG_SIZE_BIT])
            fstc_new_len = PTS_BIG;
        else if (ovl == OVL_HALF)
            fstc_new_len = PTS_HALF;
        else if (ovl == OVL_QUARTER)
            fstc_new_len = PTS_QUARTER;
        else
            fstc_new_len = PTS_SMALL;
    endfunction : fstc_new_len

endpackage : fstc_pkg

// ==== hdl/fstc_ctrl.sv ====
// sample transfer control: loading, transform start and result dumping
// assumes an external butterfly engine and workspace ram on its ports,
// strobes and enables synchronous to core_clk_i but slow enough to edge
`timescale 1ns/1ns

// small first-word-fall-through fifo, flip-flop storage
module fstc_fifo
    import fstc_pkg::*;
#(
    parameter int W     = 32,
    parameter int DEPTH = 8
)(
    // clock and reset
    input  wire logic                       core_clk_i,
    input  wire logic                       rst_i,
    // fill side
    input  wire logic                       in_valid_i,
    output logic                            in_ready_o,
    input  wire logic [W-1:0]               in_data_i,
    // drain side
    output logic                            out_valid_o,
    input  wire logic                       out_ready_i,
    output logic [W-1:0]                    out_data_o,
    output logic [$clog2(DEPTH+1)-1:0]      count_o
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [CW-1:0]           cnt;
    } fstc_fifo_st_t;
    fstc_fifo_st_t s;
    fstc_fifo_st_t next_s;
    logic          push;
    logic          pop;
    // honest flags straight from the occupancy count
    assign in_ready_o  = (s.cnt != CW'(DEPTH));
    assign out_valid_o = (s.cnt != '0);
    assign out_data_o  = s.mem[s.rp];
    assign count_o     = s.cnt;
    always_comb
    begin
        push   = in_valid_i && in_ready_o;
        pop    = out_ready_i && out_valid_o;
        next_s = s;
        if (push)
        begin
            next_s.mem[s.wp] = in_data_i;
            next_s.wp        = (s.wp == PW'(DEPTH-1)) ? '0 : s.wp + 1'b1;
        end
        if (pop)
            next_s.rp = (s.rp == PW'(DEPTH-1)) ? '0 : s.rp + 1'b1;
        next_s.cnt = s.cnt + CW'(push) - CW'(pop);
    end
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            s <= '0;
        else
            s <= next_s;
    end
endmodule : fstc_fifo

// Behaviour
// - samples taken on the input strobe rising edge, no external buffer
// - results leave under their own output strobe at any faster rate
// - input strobe divided by two or four when strobes share a clock
// - small transforms double buffered, load, compute and dump concurrent
// - overlap reuses stored samples, fewer new samples per transform
// - window weighting enabled during first transform pass, not loading
// - large mode runs load, transform and dump as separate phases
// - large mode always loads full 1024 words; source re-supplies overlap
// - without concurrency input and output may run at up to half the system clock rate
// - pseudo mode 2 separates phases; dump enable high at end blocks flag
// - transform starts by itself once enough samples are loaded
// - three output strobes prime the buffer; the fourth shows the first result
// - mode field 00 means single device, else multiple-device mode
module fstc_ctrl
    import fstc_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    // configuration port
    input  wire logic              config_load_n_i,
    input  wire logic [CFG_W-1:0]  cfg_i,
    // sample loading side
    input  wire logic              input_sample_strobe_i,
    input  wire logic              load_enable_n_i,
    input  wire logic [DATA_W-1:0] in_data_i,
    output logic                   loading_flag_o,
    // workspace write port
    output fstc_ws_wr_t            ws_wr_o,
    // transform engine handshake
    output logic                   xf_start_o,
    output logic [ADDR_W-1:0]      xf_base_o,
    output logic                   window_en_o,
    input  wire logic              xf_pass_i,
    input  wire logic              xf_done_i,
    // results from engine
    input  wire logic              res_valid_i,
    input  wire logic [DATA_W-1:0] res_data_i,
    output logic                   res_ready_o,
    // dumping side
    input  wire logic              output_sample_strobe_i,
    input  wire logic              dump_enable_n_i,
    output logic [DATA_W-1:0]      out_data_o,
    output logic                   results_available_n_o
);
    localparam int FCW = $clog2(FIFO_DEPTH+1);
    typedef struct packed {
        logic [2:0]        sync_in;
        logic [2:0]        sync_out;
        logic [CFG_W-1:0]  cfg;
        logic [1:0]        div_cnt;
        logic [CNT_W-1:0]  load_cnt;
        logic [ADDR_W-1:0] wr_ptr;
        logic              filled;
        logic              loading;
        logic              block_full;
        fstc_xf_t          xf;
        fstc_dm_t          dm;
        logic [2:0]        prime_cnt;
        logic [CNT_W-1:0]  res_cnt;
        logic [CNT_W-1:0]  pop_cnt;
        fstc_ws_wr_t       ws;
        logic              xf_start;
        logic [ADDR_W-1:0] xf_base;
        logic              window_en;
        logic              res_ready;
        logic [DATA_W-1:0] out_data;
        logic              dav_n;
    } fstc_st_t;
    fstc_st_t          s;
    fstc_st_t          next_s;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;
    logic [FCW-1:0]    fifo_count;
    logic              push;
    logic              pop;
    // registered outputs
    assign loading_flag_o        = s.loading;
    assign ws_wr_o               = s.ws;
    assign xf_start_o            = s.xf_start;
    assign xf_base_o             = s.xf_base;
    assign window_en_o           = s.window_en;
    assign res_ready_o           = s.res_ready;
    assign out_data_o            = s.out_data;
    assign results_available_n_o = s.dav_n;
    // separate output buffer between engine and output pins
    fstc_fifo #(.W (DATA_W), .DEPTH (FIFO_DEPTH)) u_out_fifo (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (res_data_i),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (pop),
        .out_data_o  (fifo_out_data),
        .count_o     (fifo_count)
    );
    // all sequencing in one next-state process
    always_comb
    begin
        logic             edge_in;
        logic             edge_out;
        logic             big;
        logic             separate;
        logic             multi;
        logic             load_ok;
        logic             strobe_ok;
        logic [1:0]       div_mask;
        logic [CNT_W-1:0] need;
        logic [CNT_W-1:0] blen;
        logic [CNT_W-1:0] res_nx;
        logic [FCW-1:0]   cnt_nx;
        next_s = s;
        if (!config_load_n_i)
        begin
            // config load clears all control state but not the output buffer, keeps the shown word
            next_s          = '0;
            next_s.cfg      = cfg_i;
            next_s.out_data = s.out_data;
            next_s.dav_n    = 1'b1;
        end
        next_s.ws.wr    = 1'b0;
        next_s.xf_start = 1'b0;
        // two flops, then edge detect on the settled stages only
        next_s.sync_in  = {s.sync_in[1:0],
                           input_sample_strobe_i};
        next_s.sync_out = {s.sync_out[1:0],
                           output_sample_strobe_i};
        edge_in   = s.sync_in[1] & ~s.sync_in[2];
        edge_out  = s.sync_out[1] & ~s.sync_out[2];
        big       = s.cfg[CFG_SIZE_BIT];
        multi     = (s.cfg[CFG_MODE_LO +: 2] != MODE_SINGLE);
        separate  = big ||
                    (s.cfg[CFG_MODE_LO +: 2] == MODE_PSEUDO2);
        blen      = fstc_block_len(s.cfg);
        // first block fills the workspace; later small-mode ones only top it up
        need      = s.filled ? fstc_new_len(s.cfg) : blen;
        // loading stalls while a full block waits, or in phase modes while the transform or dump runs
        load_ok   = !load_enable_n_i && !s.block_full &&
                    (!separate || (s.xf == XF_IDLE && s.dm == DM_IDLE));
        // multi modes count output strobes without dump enable
        strobe_ok = edge_out && (!dump_enable_n_i || multi);
        // engine results into the output buffer
        push      = config_load_n_i && res_valid_i && s.res_ready &&
                    fifo_in_ready;
        res_nx    = s.res_cnt + CNT_W'(push);
        pop       = 1'b0;
        cnt_nx    = '0;
        case (s.cfg[CFG_DIV_LO +: 2])
            DIV_BY2: div_mask = 2'h1;
            DIV_BY4: div_mask = 2'h3;
            default: div_mask = 2'h0;
        endcase
        if (config_load_n_i)
        begin
            if (edge_in && load_ok)
            begin
                next_s.div_cnt = (s.div_cnt + 2'h1) & div_mask;
                if (s.div_cnt == 2'h0)
                begin
                    // one word per edge kept by the divider; no extra wait state
                    next_s.ws.wr   = 1'b1;
                    next_s.ws.data = in_data_i;
                    next_s.ws.addr = big ? s.load_cnt[ADDR_W-1:0]
                                         : (s.wr_ptr & CIRC_MASK);
                    next_s.wr_ptr  = (s.wr_ptr + 10'h001) & CIRC_MASK;
                    next_s.loading = 1'b1;
                    next_s.load_cnt = s.load_cnt + 11'h001;
                    if (s.load_cnt + 11'h001 == need)
                    begin
                        next_s.loading    = 1'b0;
                        next_s.load_cnt   = '0;
                        next_s.block_full = 1'b1;
                    end
                end
            end
            // automatic start; phase modes wait for the dump to finish
            if (s.block_full && s.xf == XF_IDLE &&
                (!separate || s.dm == DM_IDLE))
            begin
                next_s.xf_start   = 1'b1;
                next_s.xf         = XF_RUN;
                next_s.block_full = 1'b0;
                next_s.filled     = !big;
                next_s.window_en  = 1'b1;
                next_s.xf_base    = big ? '0
                                  : ((s.wr_ptr - SMALL_SPAN) & CIRC_MASK);
            end
            // weighting only lasts for the first pass
            if (s.window_en && xf_pass_i)
                next_s.window_en = 1'b0;
            // completion hands over to the dump side when it is free
            if (s.xf == XF_RUN && xf_done_i && s.dm == DM_IDLE)
            begin
                next_s.xf        = XF_IDLE;
                next_s.res_cnt   = '0;
                next_s.pop_cnt   = '0;
                next_s.prime_cnt = '0;
                next_s.window_en = 1'b0;
                // pseudo mode 2 never raises the flag if dump enable is high
                if (s.cfg[CFG_MODE_LO +: 2] == MODE_PSEUDO2 &&
                    dump_enable_n_i)
                    next_s.dm = DM_HOLD;
                else
                    next_s.dm = DM_PRIME;
            end
            next_s.res_cnt = res_nx;
            case (s.dm)
                DM_PRIME:
                begin
                    if (strobe_ok && fifo_out_valid)
                    begin
                        next_s.prime_cnt = s.prime_cnt + 3'h1;
                        if (s.prime_cnt + 3'h1 == PRIME_STROBES)
                        begin
                            pop             = 1'b1;
                            next_s.out_data = fifo_out_data;
                            next_s.pop_cnt  = s.pop_cnt + 11'h001;
                            next_s.dav_n    = 1'b0;
                            next_s.dm       = DM_AVAIL;
                        end
                    end
                end
                DM_AVAIL:
                begin
                    if (strobe_ok && fifo_out_valid)
                    begin
                        pop             = 1'b1;
                        next_s.out_data = fifo_out_data;
                        next_s.pop_cnt  = s.pop_cnt + 11'h001;
                        if (s.pop_cnt + 11'h001 == blen)
                        begin
                            next_s.dav_n = 1'b1;
                            next_s.dm    = DM_IDLE;
                        end
                    end
                end
                default:
                begin
                    // idle drains words left by a config clear; held waits
                    pop = (s.dm == DM_IDLE) && fifo_out_valid;
                end
            endcase
            // ready looks one cycle ahead so a push never overfills
            cnt_nx = fifo_count + FCW'(push) - FCW'(pop);
            next_s.res_ready = (next_s.dm == DM_PRIME ||
                                next_s.dm == DM_AVAIL) &&
                               (res_nx < blen) &&
                               (cnt_nx < FCW'(FIFO_DEPTH));
        end
    end
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s       <= '0;
            s.cfg   <= CFG_RESET;
            s.dav_n <= 1'b1;
        end
        else
            s <= next_s;
    end
endmodule : fstc_ctrl

// ==== tb/fstc_ctrl_props.sv ====
// concurrent checks on the sample transfer control ports
// assumes a bind onto fstc_ctrl; one clock, reset active high
`timescale 1ns/1ns
module fstc_ctrl_props
    import fstc_pkg::*;
(
    // clock and reset
    input wire logic              core_clk_i,
    input wire logic              rst_i,
    // loading side
    input wire logic              config_load_n_i,
    input wire logic              input_sample_strobe_i,
    input wire logic              load_enable_n_i,
    input wire logic              loading_flag_o,
    input wire fstc_ws_wr_t       ws_wr_o,
    // transform and dumping side
    input wire logic              xf_start_o,
    input wire logic              window_en_o,
    input wire logic              xf_pass_i,
    input wire logic              output_sample_strobe_i,
    input wire logic [DATA_W-1:0] out_data_o,
    input wire logic              results_available_n_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    // output strobe rise seen three edges back, through the synchroniser
    sequence s_out_edge;
        $past(output_sample_strobe_i, 3) && !$past(output_sample_strobe_i, 4);
    endsequence

    // sample writes follow a fresh strobe rise by exactly three edges
    a_wr_after_rise: assert property (ws_wr_o.wr |->
        $past(input_sample_strobe_i, 3) && !$past(input_sample_strobe_i, 4))
        else $error("write without strobe edge");
    a_wr_one_cycle: assert property (
        ws_wr_o.wr |=> !ws_wr_o.wr)
        else $error("sample write longer than one cycle");
    a_wr_enabled: assert property (ws_wr_o.wr |->
        !$past(load_enable_n_i) && $past(config_load_n_i))
        else $error("sample write while loading disabled");
    a_flag_first: assert property (
        $rose(loading_flag_o) |-> ws_wr_o.wr)
        else $error("loading flag rose without a write");
    a_start_single: assert property (
        xf_start_o |=> !xf_start_o)
        else $error("transform start longer than one cycle");
    a_start_window: assert property (
        xf_start_o |-> window_en_o)
        else $error("window off at transform start");
    a_window_pass: assert property (
        xf_pass_i && window_en_o |=> !window_en_o)
        else $error("window still on after first pass");
    a_window_cause: assert property (
        $rose(window_en_o) |-> xf_start_o)
        else $error("window on without start");
    a_prime_edge: assert property (
        $fell(results_available_n_o) |-> s_out_edge)
        else $error("flag fell without strobe edge");
    a_pop_edge: assert property (
        $changed(out_data_o) && $past(config_load_n_i) |-> s_out_edge)
        else $error("word changed without strobe edge");

    // main scenarios reached
    c_start: cover property (xf_start_o);
    c_avail: cover property ($fell(results_available_n_o));
    c_pass: cover property (xf_pass_i && window_en_o);
endmodule : fstc_ctrl_props

// ==== tb/fstc_engine_model.sv ====
// behavioural transform engine facing the transfer control block
// assumes result words are numbered from zero within each block
`timescale 1ns/1ns
module fstc_engine_model
    import fstc_pkg::*;
#(
    parameter int DONE_LAT = 40 // below block acquisition
)(
    // clock, reset and config clear
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    input  wire logic              clear_n_i,
    input  wire logic              size_big_i,
    // transform handshake
    input  wire logic              xf_start_i,
    output logic                   xf_pass_o,
    output logic                   xf_done_o,
    // result stream
    output logic                   res_valid_o,
    output logic [DATA_W-1:0]      res_data_o,
    input  wire logic              res_ready_i
);
    logic        run;
    logic        strm;
    int          cnt;
    logic [10:0] idx;

    // done held until taken; words offered with random gaps
    always @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i || !clear_n_i)
        begin
            run <= 1'b0;
            strm <= 1'b0;
            cnt <= 0;
            idx <= '0;
            xf_pass_o <= 1'b0;
            xf_done_o <= 1'b0;
            res_valid_o <= 1'b0;
            res_data_o <= '0;
        end
        else
        begin
            xf_pass_o <= 1'b0;
            if (xf_start_i)
                cnt <= 0;
            else if (run)
                cnt <= cnt + 1;
            if (xf_start_i)
                run <= 1'b1;
            if (run && cnt == DONE_LAT / 2)
                xf_pass_o <= 1'b1; // first pass ends
            if (run && cnt == DONE_LAT)
                xf_done_o <= 1'b1;
            if (xf_done_o && res_ready_i && !strm)
            begin
                xf_done_o <= 1'b0;
                run <= 1'b0;
                strm <= 1'b1;
                idx <= '0;
            end
            // released data flips so a stale word never looks valid
            if (res_valid_o && res_ready_i)
            begin
                res_valid_o <= 1'b0;
                res_data_o <= ~res_data_o;
                idx <= idx + 11'h001;
            end
            else if (strm && !res_valid_o && $urandom_range(0, 3) != 0)
            begin
                if (idx == (size_big_i ? PTS_BIG : PTS_SMALL))
                    strm <= 1'b0;
                else
                begin
                    res_valid_o <= 1'b1;
                    res_data_o <= {8'hC3, 13'h0000, idx};
                end
            end
        end
    end
endmodule : fstc_engine_model

// ==== tb/tb.sv ====
// self-checking bench for the sample transfer control block
// assumes the engine model on the far side and strobes of 4 clocks
`timescale 1ns/1ns
module tb;
    import fstc_pkg::*;
    logic              core_clk_i, rst_i, config_load_n_i;
    logic [CFG_W-1:0]  cfg_i;
    logic              input_sample_strobe_i, load_enable_n_i;
    logic [DATA_W-1:0] in_data_i, res_data_i, out_data_o, prev_out;
    logic              loading_flag_o, xf_start_o, window_en_o;
    logic              xf_pass_i, xf_done_i, res_valid_i, res_ready_o;
    logic              output_sample_strobe_i, dump_enable_n_i;
    logic              results_available_n_o;
    logic [ADDR_W-1:0] xf_base_o, ptr, amask;
    fstc_ws_wr_t       ws_wr_o;
    logic [41:0]       wq[$];
    logic [DATA_W-1:0] oq[$];
    int                error_cnt = 0;
    int                total_checks = 0;

    fstc_ctrl i_dut (
        .core_clk_i(core_clk_i), .rst_i(rst_i),
        .config_load_n_i(config_load_n_i), .cfg_i(cfg_i),
        .input_sample_strobe_i(input_sample_strobe_i),
        .load_enable_n_i(load_enable_n_i), .in_data_i(in_data_i),
        .loading_flag_o(loading_flag_o), .ws_wr_o(ws_wr_o),
        .xf_start_o(xf_start_o), .xf_base_o(xf_base_o),
        .window_en_o(window_en_o), .xf_pass_i(xf_pass_i),
        .xf_done_i(xf_done_i), .res_valid_i(res_valid_i),
        .res_data_i(res_data_i), .res_ready_o(res_ready_o),
        .output_sample_strobe_i(output_sample_strobe_i),
        .dump_enable_n_i(dump_enable_n_i), .out_data_o(out_data_o),
        .results_available_n_o(results_available_n_o));

    fstc_engine_model i_eng (
        .core_clk_i(core_clk_i), .rst_i(rst_i),
        .clear_n_i(config_load_n_i), .size_big_i(cfg_i[0]),
        .xf_start_i(xf_start_o), .xf_pass_o(xf_pass_i),
        .xf_done_o(xf_done_i), .res_valid_o(res_valid_i),
        .res_data_o(res_data_i), .res_ready_i(res_ready_o));

    task automatic chk(input logic [41:0] seen, input logic [41:0] exp,
                       input string what);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic report_and_stop;
        if (error_cnt == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask : tick

    task automatic cfgload(input logic [CFG_W-1:0] v);
        config_load_n_i = 1'b0;
        cfg_i = v;
        tick(1);
        config_load_n_i = 1'b1;
        ptr = '0;
        amask = v[0] ? 10'h3FF : 10'h1FF;
    endtask : cfgload

    // strobe period of 4 clocks keeps well under the rate limit
    task automatic load(input int n, input int div, input bit acc);
        logic [DATA_W-1:0] d;
        for (int i = 0; i < n; i++)
        begin
            d = $urandom;
            in_data_i = d;
            input_sample_strobe_i = 1'b1;
            if (acc && i % div == 0)
            begin
                wq.push_back({ptr & amask, d});
                ptr++;
            end
            tick(2);
            input_sample_strobe_i = 1'b0;
            tick(2);
        end
    endtask : load

    task automatic wait_start(input logic [ADDR_W-1:0] base);
        int k;
        for (k = 0; k < 3000 && xf_start_o !== 1'b1; k++)
            tick(1);
        if (k == 3000)
        begin
            chk(1'b0, 1'b1, "transform start timeout");
            report_and_stop();
        end
        chk(xf_base_o, base, "xf_base_o");
    endtask : wait_start

    // first three enabled strobes only prime the output buffer
    task automatic dump(input int n, input bit live);
        for (int i = 0; i < n; i++)
        begin
            if (i == 3)
                chk(results_available_n_o, 1'b1, "flag primed");
            if (i == 4)
                chk(results_available_n_o, !live, "flag");
            if (live && i >= 3)
                oq.push_back({8'hC3, 13'h0000, 11'(i - 3)});
            output_sample_strobe_i = 1'b1;
            tick(2);
            output_sample_strobe_i = 1'b0;
            tick(2);
        end
    endtask : dump

    initial
    begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    // watch writes and result words against the oldest note
    always @(negedge core_clk_i)
    begin
        if (ws_wr_o.wr === 1'b1 && wq.size() == 0)
            chk(1'b1, 1'b0, "refused write");
        else if (ws_wr_o.wr === 1'b1)
            chk({ws_wr_o.addr, ws_wr_o.data}, wq.pop_front(), "ws");
        if (out_data_o !== prev_out && oq.size() != 0)
            chk(out_data_o, oq.pop_front(), "out_data_o");
        else if (out_data_o !== prev_out && out_data_o !== '0)
            chk(out_data_o, '0, "unexpected word");
        prev_out = out_data_o;
    end

    initial
    begin
        {rst_i, config_load_n_i, load_enable_n_i} = 3'h7;
        {input_sample_strobe_i, output_sample_strobe_i} = 2'h0;
        {cfg_i, in_data_i, prev_out, ptr} = '0;
        dump_enable_n_i = 1'b0;
        amask = 10'h1FF;
        void'($urandom(32'h5A7F));
        tick(3);
        rst_i = 1'b0;
        chk({results_available_n_o, loading_flag_o}, 2'h2, "reset");
        load(4, 1, 0);
        load_enable_n_i = 1'b0;
        // plain block, buffer filled until it refuses, then drained
        load(256, 1, 1);
        wait_start(10'h000);
        tick(100);
        chk(res_ready_o, 1'b0, "res_ready_o full");
        dump(259, 1);
        chk({results_available_n_o, 6'(oq.size())}, 7'h40, "drained");
        // half and quarter overlap reuse stored samples
        for (int j = 1; j <= 2; j++)
        begin
            cfgload(16'(j << 1));
            load(256, 1, 1);
            wait_start(10'h000);
            load(256 >> j, 1, 1);
            wait_start(10'(256 >> j));
        end
        // shared-clock divider by two and by four
        for (int j = 1; j <= 2; j++)
        begin
            cfgload(16'(j << 3));
            load(8, 1 << j, 1);
        end
        // large mode: loading refused while transform and dump run
        cfgload(16'h0001);
        load(1024, 1, 1);
        wait_start(10'h000);
        load(5, 1, 0);
        tick(100);
        load(3, 1, 0);
        // pseudo mode 2 with dump enable high at the end of transform
        cfgload(16'h0400);
        dump_enable_n_i = 1'b1;
        load(256, 1, 1);
        wait_start(10'h000);
        tick(100);
        dump(8, 0);
        // other multi mode needs no dump enable for priming
        cfgload(16'h0200);
        load(256, 1, 1);
        wait_start(10'h000);
        tick(100);
        dump(259, 1);
        chk(oq.size() == 0, 1'b1, "multi drained");
        report_and_stop();
    end
endmodule : tb

bind fstc_ctrl fstc_ctrl_props i_props (
    .core_clk_i(core_clk_i), .rst_i(rst_i),
    .config_load_n_i(config_load_n_i),
    .input_sample_strobe_i(input_sample_strobe_i),
    .load_enable_n_i(load_enable_n_i), .loading_flag_o(loading_flag_o),
    .ws_wr_o(ws_wr_o), .xf_start_o(xf_start_o), .window_en_o(window_en_o),
    .xf_pass_i(xf_pass_i), .output_sample_strobe_i(output_sample_strobe_i),
    .out_data_o(out_data_o), .results_available_n_o(results_available_n_o));
